// ---- rtl/sipo_shift_latch_output_gate.sv ----
// Overview of operation
// - Each shift edge moves serial_in into stage zero
// - Sixteen stages, newest on output zero
// - Sixteen independent sink outputs from latch bits
// - Strobe high: latch follows shift register
// - Strobe low: latch holds, shifting continues
// - Enable high forces all sink outputs off
// - One enable gates all sixteen outputs together
// - Enable pulses of 40 ns are honoured
// - serial_out presents the sixteenth stage
// - Reset holds every output off
`timescale 1ns/10ps
module sipo_shift_latch_output_gate
#(
  parameter int NUM_STAGES = led_sink_pkg::STAGES
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic shift_clk_i,
  input wire logic serial_in_i,
  input wire logic latch_strobe_n_i,
  input wire logic output_enable_n_i,
  output logic serial_out_o,
  output logic [led_sink_pkg::STAGES-1:0] sink_on_o
);
  import led_sink_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shift register on the shift clock
  ////////////////////////////////////////////////////////////////////////////

  logic [STAGES-1:0] shift_q;
  logic [EDGE_CNT_W-1:0] edge_bin_q;
  logic [EDGE_CNT_W-1:0] edge_gray_q;
  logic [EDGE_CNT_W-1:0] edge_bin_d;
  logic [STAGES-2:0] shift_low;
  logic stage_before_last;
  logic link_live_q;

  // Newest bit enters stage zero, older bits move onward
  always_ff @(posedge shift_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_q <= SHIFT_RST;
    end else begin
      shift_q <= {shift_q[STAGES-2:0], serial_in_i};
    end
  end

  // Cascade output straight from the last stage
  assign serial_out_o = shift_q[LAST_STAGE];

  // Views used by the checks below
  assign shift_low = shift_q[STAGES-2:0];
  assign stage_before_last = shift_q[LAST_STAGE-1];

  // Edge counter, gray coded so the core sees one bit change per edge
  assign edge_bin_d = edge_bin_q + 4'h1;

  always_ff @(posedge shift_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edge_bin_q <= EDGE_CNT_RST;
      edge_gray_q <= EDGE_CNT_RST;
    end else begin
      edge_bin_q <= edge_bin_d;
      edge_gray_q <= edge_bin_d ^ (edge_bin_d >> 1);
    end
  end

  // First shift edge since reset, so edge history checks wait for it
  always_ff @(posedge shift_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_live_q <= 1'b0;
    end else begin
      link_live_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the core domain
  ////////////////////////////////////////////////////////////////////////////

  logic [EDGE_CNT_W-1:0] gray_s;
  logic [STAGES-1:0] word_s;
  logic [CTRL_W-1:0] ctrl_async;
  logic [CTRL_W-1:0] ctrl_s;
  logic strobe_s;
  logic oe_n_s;

  // Edge count crosses as gray code
  sync_2ff #(
    .WIDTH(EDGE_CNT_W)
  ) u_sync_gray (
    .clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i(edge_gray_q),
    .sync_o(gray_s)
  );

  // Shift word, trusted only once the edge count has settled
  sync_2ff #(
    .WIDTH(STAGES)
  ) u_sync_word (
    .clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i(shift_q),
    .sync_o(word_s)
  );

  // Strobe and enable pins, both asynchronous to the core clock
  assign ctrl_async[CTRL_STROBE_BIT] = latch_strobe_n_i;
  assign ctrl_async[CTRL_OE_N_BIT] = output_enable_n_i;

  sync_2ff #(
    .WIDTH(CTRL_W)
  ) u_sync_ctrl (
    .clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i(ctrl_async),
    .sync_o(ctrl_s)
  );

  // Strobe pin is active high for transparency despite its name
  assign strobe_s = ctrl_s[CTRL_STROBE_BIT];
  assign oe_n_s = ctrl_s[CTRL_OE_N_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Settle detection on the crossed shift word
  ////////////////////////////////////////////////////////////////////////////

  logic [EDGE_CNT_W-1:0] gray_prev_q;
  logic [SETTLE_W-1:0] settle_q;
  logic settled;

  // Counts core cycles with no new shift edge, saturating
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gray_prev_q <= EDGE_CNT_RST;
      settle_q <= SETTLE_RST;
    end else begin
      gray_prev_q <= gray_s;
      if (gray_s != gray_prev_q) begin
        settle_q <= SETTLE_RST;
      end else if (settle_q != SETTLE_CYC) begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // Word bits have all resolved once the count has stood still
  assign settled = (settle_q == SETTLE_CYC) && (gray_s == gray_prev_q);

  ////////////////////////////////////////////////////////////////////////////
  // Output latch
  ////////////////////////////////////////////////////////////////////////////

  logic [STAGES-1:0] latch_q;

  // Transparent while the strobe is high, holding while it is low
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latch_q <= LATCH_RST;
    end else if (strobe_s && settled) begin
      latch_q <= word_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output gate, one bit per sink
  ////////////////////////////////////////////////////////////////////////////

  // Single enable gates every sink at once
  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_sink
      always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sink_on_o[g] <= SINK_OFF[g];
        end else begin
          sink_on_o[g] <= latch_q[g] & ~oe_n_s;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks, link domain
  ////////////////////////////////////////////////////////////////////////////

  // Every edge shifts the pin into stage zero
  AST_SHIFT_IN: assert property (
    @(posedge shift_clk_i) disable iff (!rstn_i)
    link_live_q |-> shift_q[0] == $past(serial_in_i)
  ) else $error("stage zero missed the serial input");

  // Older bits advance exactly one stage per edge
  AST_SHIFT_ON: assert property (
    @(posedge shift_clk_i) disable iff (!rstn_i)
    link_live_q |-> shift_q[STAGES-1:1] == $past(shift_low)
  ) else $error("shift stages did not advance by one");

  // A bit shifted in reaches serial_out fifteen edges later
  AST_CASCADE: assert property (
    @(posedge shift_clk_i) disable iff (!rstn_i)
    link_live_q |-> serial_out_o == $past(stage_before_last)
  ) else $error("serial output does not follow last stage");

  // Gray count moves by exactly one bit per shift edge
  AST_GRAY_STEP: assert property (
    @(posedge shift_clk_i) disable iff (!rstn_i)
    link_live_q |-> $onehot(edge_gray_q ^ $past(edge_gray_q))
  ) else $error("edge count crossed with more than one bit change");

  // Every shift edge advances the edge count by one
  AST_EDGE_COUNT: assert property (
    @(posedge shift_clk_i) disable iff (!rstn_i)
    link_live_q |-> edge_bin_q == $past(edge_bin_q) + 4'h1
  ) else $error("edge count skipped or stalled");

  ////////////////////////////////////////////////////////////////////////////
  // Checks, core domain
  ////////////////////////////////////////////////////////////////////////////

  // Strobe low freezes the latch whatever the link does
  AST_LATCH_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    !strobe_s |=> $stable(latch_q)
  ) else $error("latch changed while strobe low");

  // Strobe high on a settled word loads it on the next edge
  AST_LATCH_FOLLOW: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (strobe_s && settled) |=> latch_q == $past(word_s)
  ) else $error("transparent latch did not follow shift word");

  // Settled only after two quiet cycles on the edge count
  AST_SETTLE: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (gray_s != gray_prev_q) |=> !settled [*2]
  ) else $error("word trusted too soon after a shift edge");

  // Enable high forces every sink off on the next edge
  AST_GATE_OFF: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    oe_n_s |=> sink_on_o == SINK_OFF
  ) else $error("a sink stayed on with enable high");

  // Enable low shows the whole latch at once
  AST_GATE_ALL: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    !oe_n_s |=> sink_on_o == $past(latch_q)
  ) else $error("sinks do not match latch with enable low");

  // A one cycle enable pulse still lights the latched sinks
  AST_OE_PULSE: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (oe_n_s ##1 (!oe_n_s && latch_q != LATCH_RST) ##1 oe_n_s)
      |-> sink_on_o != SINK_OFF ##1 sink_on_o == SINK_OFF
  ) else $error("short enable pulse not honoured");

  // Empty latch after reset keeps the sinks off
  AST_RESET_OFF: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (latch_q == LATCH_RST) |=> sink_on_o == SINK_OFF
  ) else $error("sink on while latch is clear");

  // Unsettled word never reaches the latch
  AST_LOAD_SETTLED: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    !settled |=> $stable(latch_q)
  ) else $error("latch loaded a word still in flight");

  // Three quiet samples of the edge count make the word trusted
  AST_QUIET_TRUST: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (gray_s == gray_prev_q) [*3] |-> settled
  ) else $error("quiet shift word not trusted");

  // Held latch with enable low keeps every sink still
  AST_HOLD_SINKS: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (!strobe_s && !oe_n_s) [*2] |=> $stable(sink_on_o)
  ) else $error("sinks moved while latch held");

  // A sink conducts only where its latch bit is set
  AST_SINK_SUBSET: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (sink_on_o & ~$past(latch_q)) == SINK_OFF
  ) else $error("sink on without its latch bit");

  // A one cycle enable high pulse still blanks every sink
  AST_OE_OFF_PULSE: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (!oe_n_s ##1 oe_n_s ##1 !oe_n_s) |-> sink_on_o == SINK_OFF
  ) else $error("short blanking pulse not honoured");

  ////////////////////////////////////////////////////////////////////////////
  // Checks, reset
  ////////////////////////////////////////////////////////////////////////////

  // Reset held keeps every sink and the cascade output low
  AST_RESET_PINS: assert property (
    @(posedge core_clk_i)
    !rstn_i |-> (sink_on_o == SINK_OFF) && !serial_out_o
  ) else $error("output active while reset held");

endmodule

// ---- rtl/led_sink_pkg.sv ----
package led_sink_pkg;

  // Shift register and output geometry
  localparam int STAGES = 16;
  localparam int LAST_STAGE = STAGES - 1;

  // Reset values of the shift register, the latch and the outputs
  localparam logic [STAGES-1:0] SHIFT_RST = 16'h0000;
  localparam logic [STAGES-1:0] LATCH_RST = 16'h0000;
  localparam logic [STAGES-1:0] SINK_OFF = 16'h0000;

  // Core clock and link timing
  localparam int CORE_CLK_PERIOD_NS = 40;
  localparam int LINK_CLK_MAX_MHZ = 25;
  localparam int OE_MIN_PULSE_NS = 40;
  localparam int OE_MIN_PULSE_CYC_RAW =
    (OE_MIN_PULSE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int OE_MIN_PULSE_CYC =
    (OE_MIN_PULSE_CYC_RAW < 1) ? 1 : OE_MIN_PULSE_CYC_RAW;

  // Crossing of the shift word into the core domain
  localparam int EDGE_CNT_W = 4;
  localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RST = 4'h0;
  localparam int SETTLE_W = 2;
  localparam logic [SETTLE_W-1:0] SETTLE_CYC = 2'h2;
  localparam logic [SETTLE_W-1:0] SETTLE_RST = 2'h0;

  // Positions of the control pins in the synchroniser bundle
  localparam int CTRL_W = 2;
  localparam int CTRL_STROBE_BIT = 0;
  localparam int CTRL_OE_N_BIT = 1;

endpackage

// ---- rtl/sync_2ff.sv ----
`timescale 1ns/10ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // Two flip-flop synchroniser, first stage read only by the second
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ---- verif/display_ctrl_model.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// Controller that shifts frames into the driver chain
module display_ctrl_model (
  input wire logic serial_out_i,
  output logic shift_clk_o,
  output logic serial_data_o
);
  logic [15:0] rx_q;

  // Link clock stands low between frames
  initial begin
    shift_clk_o = 1'b0;
    serial_data_o = 1'b0;
    rx_q = 16'h0000;
  end

  // One frame, first bit ends up in the last stage
  task automatic send_frame(input logic [15:0] word);
    #13;
    for (int i = 15; i >= 0; i--) begin
      serial_data_o = word[i];
      #32 shift_clk_o = 1'b1;
      #32 shift_clk_o = 1'b0;
      rx_q = {rx_q[14:0], serial_out_i};
    end
    serial_data_o = ~word[0]; // Released line drops the last bit
  endtask
endmodule

// ---- verif/sipo_shift_latch_output_gate_tb.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module sipo_shift_latch_output_gate_tb;
  import led_sink_pkg::*;
  localparam logic [15:0] W_A = 16'ha5c3;
  localparam logic [15:0] W_B = 16'h3c5a;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b1;
  logic latch_strobe_n_i = 1'b1;
  logic output_enable_n_i = 1'b0;
  logic shift_clk;
  logic serial_in;
  logic serial_out_o;
  logic [STAGES-1:0] sink_on_o;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;

  // Core clock, 40 ns
  always #20 core_clk_i = ~core_clk_i;

  sipo_shift_latch_output_gate u_sipo_shift_latch_output_gate (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .shift_clk_i(shift_clk),
    .serial_in_i(serial_in),
    .latch_strobe_n_i(latch_strobe_n_i),
    .output_enable_n_i(output_enable_n_i),
    .serial_out_o(serial_out_o),
    .sink_on_o(sink_on_o)
  );

  display_ctrl_model u_display_ctrl_model (
    .serial_out_i(serial_out_o),
    .shift_clk_o(shift_clk),
    .serial_data_o(serial_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic drive(input logic strobe, input logic oe_n);
    @(posedge core_clk_i);
    #1;
    latch_strobe_n_i = strobe;
    output_enable_n_i = oe_n;
  endtask

  task automatic settle();
    repeat (12) @(posedge core_clk_i);
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    #1;
    rstn_i = 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1;
    check(sink_on_o, SINK_OFF);
    check({15'h0000, serial_out_o}, 16'h0000);
    rstn_i = 1'b1;
    settle();
    check(sink_on_o, LATCH_RST);
  endtask

  task automatic t_follow();
    u_display_ctrl_model.send_frame(W_A);
    settle();
    check(sink_on_o, W_A);
  endtask

  task automatic t_hold();
    drive(1'b0, 1'b0);
    u_display_ctrl_model.send_frame(W_B);
    settle();
    check(sink_on_o, W_A);
    check(u_display_ctrl_model.rx_q, {W_A[14:0], W_B[15]});
    drive(1'b1, 1'b0);
    settle();
    check(sink_on_o, W_B);
  endtask

  task automatic t_gate();
    drive(1'b1, 1'b1);
    settle();
    check(sink_on_o, SINK_OFF);
    u_display_ctrl_model.send_frame(W_A);
    settle();
    check(sink_on_o, SINK_OFF);
    drive(1'b1, 1'b0);
    settle();
    check(sink_on_o, W_A);
  endtask

  task automatic t_pulse();
    logic seen_off;
    logic seen_on;
    seen_off = 1'b0;
    seen_on = 1'b0;
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
    repeat (8) begin
      @(posedge core_clk_i);
      #1;
      if (sink_on_o === SINK_OFF) begin
        seen_off = 1'b1;
      end
    end
    check({15'h0000, seen_off}, 16'h0001);
    settle();
    check(sink_on_o, W_A);
    // One core period of enable low must still light the sinks
    drive(1'b1, 1'b1);
    settle();
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
    repeat (8) begin
      @(posedge core_clk_i);
      #1;
      if (sink_on_o === W_A) begin
        seen_on = 1'b1;
      end
    end
    check({15'h0000, seen_on}, 16'h0001);
    check(sink_on_o, SINK_OFF);
    drive(1'b1, 1'b0);
    settle();
    check(sink_on_o, W_A);
  endtask

  task automatic t_rearm();
    drive(1'b0, 1'b0);
    settle();
    check(sink_on_o, W_A);
    @(posedge core_clk_i);
    #1;
    rstn_i = 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1;
    check(sink_on_o, SINK_OFF);
    check({15'h0000, serial_out_o}, 16'h0000);
    rstn_i = 1'b1;
    settle();
    check(sink_on_o, LATCH_RST);
    u_display_ctrl_model.send_frame(W_B);
    settle();
    check(sink_on_o, LATCH_RST);
    check(u_display_ctrl_model.rx_q, {SHIFT_RST[14:0], W_B[15]});
    drive(1'b1, 1'b0);
    settle();
    check(sink_on_o, W_B);
  endtask

  // Hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    t_reset();
    t_follow();
    t_hold();
    t_gate();
    t_pulse();
    t_rearm();
    end_of_test();
  end
endmodule
